// ===== inc/clsi_pkg.sv
// Constants and types shared by the camera link status light logic.
//
// Overview of operation
// - The configuration-done light is steady green once the logic image is loaded and dark otherwise.
// - The first camera light is steady red while no pixel clock comes from the first camera input and no acquisition from it runs.
// - The first camera light is steady green when its pixel clock is present but no line-valid activity is seen.
// - The first camera light flashes green at about 2 Hz when pixel clock and line-valid activity are both seen.
// - The first camera light flashes green at about 16 Hz while an acquisition from the first input runs.
// - The second camera light shows the second camera input with the same red, green, slow and fast encoding.
// - The second camera light flashes red when host link training failed and the board is not enumerated.
// - The second camera light flashes red when, in a dual-connector setup, the pixel clock comes on the secondary connector instead of the primary.
`default_nettype none

package clsi_pkg;

  // ***********************************************************************
  // Clock and timing
  // ***********************************************************************
  localparam int unsigned CLK_HZ           = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned TIMER_WIDTH      = 32;

  localparam int unsigned PCLK_TIMEOUT_NS  = 10_000;
  localparam int unsigned PCLK_TIMEOUT_CYCLES =
    PCLK_TIMEOUT_NS / CLK_PERIOD_NS;

  localparam int unsigned LVAL_TIMEOUT_MS  = 100;
  localparam int unsigned LVAL_TIMEOUT_CYCLES =
    LVAL_TIMEOUT_MS * 1_000_000 / CLK_PERIOD_NS;

  localparam int unsigned SLOW_FLASH_HZ    = 2;
  localparam int unsigned SLOW_HALF_CYCLES = CLK_HZ / (2 * SLOW_FLASH_HZ);
  localparam int unsigned FAST_FLASH_HZ    = 16;
  localparam int unsigned FAST_HALF_CYCLES = CLK_HZ / (2 * FAST_FLASH_HZ);

  // ***********************************************************************
  // Camera inputs
  // ***********************************************************************
  localparam int unsigned CAM_COUNT        = 2;
  localparam int unsigned CAM_PRIMARY      = 0;
  localparam int unsigned CAM_SECONDARY    = 1;
  localparam int unsigned SYNC_DEPTH       = 3;

  typedef enum logic [1:0] {
    VIEW_NONE,
    VIEW_CLOCK,
    VIEW_LINE,
    VIEW_ACQ
  } clsi_view_type;

endpackage

`default_nettype wire

// ===== hdl/clsi_status_lights.sv
// Status light driver for the camera inputs and the configuration state.
`timescale 1ns/100ps
`default_nettype none

module clsi_status_lights
#(
  parameter int unsigned LVAL_TIMEOUT_CYCLES = clsi_pkg::LVAL_TIMEOUT_CYCLES,
  parameter int unsigned SLOW_HALF_CYCLES    = clsi_pkg::SLOW_HALF_CYCLES,
  parameter int unsigned FAST_HALF_CYCLES    = clsi_pkg::FAST_HALF_CYCLES
)
(
  input  wire logic                           mclk,
  input  wire logic                           reset_n,
  input  wire logic [clsi_pkg::CAM_COUNT-1:0] cam_pclk,
  input  wire logic [clsi_pkg::CAM_COUNT-1:0] cam_lval,
  input  wire logic [clsi_pkg::CAM_COUNT-1:0] cam_acq_active,
  input  wire logic                           config_loaded,
  input  wire logic                           link_train_failed,
  input  wire logic                           link_enumerated,
  input  wire logic                           dual_connector_mode,
  output logic                                config_done_light_green,
  output logic      [clsi_pkg::CAM_COUNT-1:0] cam_light_red,
  output logic      [clsi_pkg::CAM_COUNT-1:0] cam_light_green
);
  import clsi_pkg::*;

  typedef logic [TIMER_WIDTH-1:0] clsi_timer_type;

  localparam clsi_timer_type PCLK_RELOAD =
    clsi_timer_type'(PCLK_TIMEOUT_CYCLES);
  localparam clsi_timer_type LVAL_RELOAD =
    clsi_timer_type'(LVAL_TIMEOUT_CYCLES);
  localparam clsi_timer_type SLOW_LAST =
    clsi_timer_type'(SLOW_HALF_CYCLES - 1);
  localparam clsi_timer_type FAST_LAST =
    clsi_timer_type'(FAST_HALF_CYCLES - 1);

  // ***********************************************************************
  // Reset release
  // ***********************************************************************
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ***********************************************************************
  // Decode helpers
  // ***********************************************************************
  function automatic clsi_view_type view_of(input logic clk_ok,
                                            input logic lval_ok,
                                            input logic acq);
    clsi_view_type view;
    if (acq)
      view = VIEW_ACQ;
    else if (lval_ok)
      view = VIEW_LINE;
    else if (clk_ok)
      view = VIEW_CLOCK;
    else
      view = VIEW_NONE;
    return view;
  endfunction

  // Returns the red and green drive, red in the upper bit.
  function automatic logic [1:0] colour_of(input clsi_view_type view,
                                           input logic slow,
                                           input logic fast);
    logic [1:0] colour;
    colour = 2'h0;
    case (view)
      VIEW_NONE:  colour = 2'h2;
      VIEW_CLOCK: colour = 2'h1;
      VIEW_LINE:  colour = {1'b0, slow};
      VIEW_ACQ:   colour = {1'b0, fast};
      default:    colour = 2'h0;
    endcase
    return colour;
  endfunction

  // ***********************************************************************
  // Per camera activity detection
  // ***********************************************************************
  logic [CAM_COUNT-1:0] pclk_present;
  logic [CAM_COUNT-1:0] lval_seen;

  for (genvar i = 0; i < CAM_COUNT; i++)
  begin : g_cam
    // Pixel clock side. The camera may stop its clock outside frames, so
    // this side only ever flips toggles; all timing lives on mclk.
    logic clk_toggle;
    logic lval_prev;
    logic lval_toggle;
    logic next_clk_toggle;
    logic next_lval_toggle;

    always_comb
    begin
      next_clk_toggle  = ~clk_toggle;
      next_lval_toggle = lval_toggle ^ (cam_lval[i] & ~lval_prev);
    end

    always_ff @(posedge cam_pclk[i] or negedge rst_n)
    begin
      if (!rst_n)
      begin
        clk_toggle  <= 1'b0;
        lval_prev   <= 1'b0;
        lval_toggle <= 1'b0;
      end
      else
      begin
        clk_toggle  <= next_clk_toggle;
        lval_prev   <= cam_lval[i];
        lval_toggle <= next_lval_toggle;
      end
    end

    // System clock side. Stage zero is the metastable flop and only
    // feeds stage one; edges are found between stages one and two.
    logic [SYNC_DEPTH-1:0] clk_sync;
    logic [SYNC_DEPTH-1:0] lval_sync;
    clsi_timer_type        pclk_timer;
    clsi_timer_type        lval_timer;
    clsi_timer_type        next_pclk_timer;
    clsi_timer_type        next_lval_timer;

    always_comb
    begin
      next_pclk_timer = pclk_timer;
      next_lval_timer = lval_timer;
      if (clk_sync[1] != clk_sync[2])
        next_pclk_timer = PCLK_RELOAD;
      else if (pclk_timer != '0)
        next_pclk_timer = pclk_timer - clsi_timer_type'(1);
      if (lval_sync[1] != lval_sync[2])
        next_lval_timer = LVAL_RELOAD;
      else if (lval_timer != '0)
        next_lval_timer = lval_timer - clsi_timer_type'(1);
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        clk_sync   <= '0;
        lval_sync  <= '0;
        pclk_timer <= '0;
        lval_timer <= '0;
      end
      else
      begin
        clk_sync   <= {clk_sync[SYNC_DEPTH-2:0], clk_toggle};
        lval_sync  <= {lval_sync[SYNC_DEPTH-2:0], lval_toggle};
        pclk_timer <= next_pclk_timer;
        lval_timer <= next_lval_timer;
      end
    end

    assign pclk_present[i] = (pclk_timer != '0);
    assign lval_seen[i]    = (lval_timer != '0) && (pclk_timer != '0);
  end

  // ***********************************************************************
  // Flash rate generators
  // ***********************************************************************
  clsi_timer_type slow_cnt;
  clsi_timer_type fast_cnt;
  logic           slow_phase;
  logic           fast_phase;
  clsi_timer_type next_slow_cnt;
  clsi_timer_type next_fast_cnt;
  logic           next_slow_phase;
  logic           next_fast_phase;

  // Each phase flips every half period, which gives an even duty cycle.
  always_comb
  begin
    next_slow_cnt   = slow_cnt + clsi_timer_type'(1);
    next_slow_phase = slow_phase;
    next_fast_cnt   = fast_cnt + clsi_timer_type'(1);
    next_fast_phase = fast_phase;
    if (slow_cnt >= SLOW_LAST)
    begin
      next_slow_cnt   = '0;
      next_slow_phase = ~slow_phase;
    end
    if (fast_cnt >= FAST_LAST)
    begin
      next_fast_cnt   = '0;
      next_fast_phase = ~fast_phase;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slow_cnt   <= '0;
      fast_cnt   <= '0;
      slow_phase <= 1'b0;
      fast_phase <= 1'b0;
    end
    else
    begin
      slow_cnt   <= next_slow_cnt;
      fast_cnt   <= next_fast_cnt;
      slow_phase <= next_slow_phase;
      fast_phase <= next_fast_phase;
    end
  end

  // ***********************************************************************
  // Light drive
  // ***********************************************************************
  logic [1:0]           cfg_sync;
  logic                 link_fault;
  logic                 next_cfg_green;
  logic [CAM_COUNT-1:0] next_red;
  logic [CAM_COUNT-1:0] next_green;

  // A wiring fault hides the camera view on the second light because the
  // camera view there would be misleading anyway.
  always_comb
  begin
    link_fault = (link_train_failed & ~link_enumerated)
               | (dual_connector_mode
                  & ~pclk_present[CAM_PRIMARY]
                  & pclk_present[CAM_SECONDARY]);
    next_cfg_green = cfg_sync[1];
    next_red       = '0;
    next_green     = '0;
    for (int i = 0; i < CAM_COUNT; i++)
    begin
      {next_red[i], next_green[i]} =
        colour_of(view_of(pclk_present[i], lval_seen[i],
                          cam_acq_active[i]),
                  slow_phase, fast_phase);
    end
    if (link_fault)
    begin
      next_red[CAM_SECONDARY]   = slow_phase;
      next_green[CAM_SECONDARY] = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_sync                <= 2'h0;
      config_done_light_green <= 1'b0;
      cam_light_red           <= '0;
      cam_light_green         <= '0;
    end
    else
    begin
      cfg_sync                <= {cfg_sync[0], config_loaded};
      config_done_light_green <= next_cfg_green;
      cam_light_red           <= next_red;
      cam_light_green         <= next_green;
    end
  end

endmodule

`default_nettype wire

// ===== test/clsi_camera_model.sv
// Behavioural camera: gated pixel clock and a line-valid pattern.
`timescale 1ns/100ps
`default_nettype none
module clsi_camera_model
(
  input  wire logic run,
  input  wire logic lval_on,
  output logic      pclk,
  output logic      lval
);
  logic [2:0] beat = 3'd0;
  // The clock stands still low while the camera is idle.
  initial pclk = 1'b0;
  always #7.5 pclk = run & ~pclk;
  always @(posedge pclk) beat <= beat + 3'd1;
  assign lval = lval_on & beat[2];
endmodule
`default_nettype wire

// ===== test/clsi_status_lights_properties.sv
// Concurrent checks on the status light outputs.
`timescale 1ns/100ps
`default_nettype none
module clsi_status_lights_properties
#(
  parameter int unsigned LVAL_TIMEOUT_CYCLES = 200,
  parameter int unsigned SLOW_HALF_CYCLES    = 40,
  parameter int unsigned FAST_HALF_CYCLES    = 8
)
(
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic [1:0] cam_pclk,
  input wire logic [1:0] cam_lval,
  input wire logic [1:0] cam_acq_active,
  input wire logic       config_loaded,
  input wire logic       link_train_failed,
  input wire logic       link_enumerated,
  input wire logic       dual_connector_mode,
  input wire logic       config_done_light_green,
  input wire logic [1:0] cam_light_red,
  input wire logic [1:0] cam_light_green
);
  logic        p0, g0, next_p0, next_g0;
  logic [10:0] idle, next_idle;
  logic [4:0]  run, next_run;
  always_comb
  begin
    next_p0 = cam_pclk[0];
    next_g0 = cam_light_green[0];
    next_idle = (cam_pclk[0] != p0) ? '0 : idle + {10'd0, idle != '1};
    next_run = (!cam_acq_active[0] || cam_light_green[0] != g0) ? '0 :
               run + {4'd0, run != '1};
  end
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      {p0, g0, idle, run} <= '0;
    else
      {p0, g0, idle, run} <= {next_p0, next_g0, next_idle, next_run};
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_lights_exclusive: assert property (
    (cam_light_red & cam_light_green) == 2'b00)
    else $error("red and green lit together");
  a_cfg_follows: assert property (
    $stable(config_loaded)[*6] |->
      config_done_light_green == config_loaded)
    else $error("config light wrong");
  a_acq_not_red: assert property (
    cam_acq_active[0] && $past(cam_acq_active[0]) |-> !cam_light_red[0])
    else $error("red during acquisition");
  a_fast_period: assert property (run <= FAST_HALF_CYCLES + 4)
    else $error("fast flash too slow");
  a_fault_no_green: assert property (
    $past(link_train_failed && !link_enumerated) |-> !cam_light_green[1])
    else $error("green during link fault");
  a_lost_clock_red: assert property (
    idle > 11'd1012 && !cam_acq_active[0] && !$past(cam_acq_active[0])
      |-> cam_light_red[0])
    else $error("no red after clock loss");
  a_acq1_not_red: assert property (
    cam_acq_active[1] && $past(cam_acq_active[1]) &&
      !$past(link_train_failed) && !$past(dual_connector_mode)
      |-> !cam_light_red[1])
    else $error("red on second light");
  a_dark_reset: assert property (
    @(posedge mclk) disable iff (1'b0) !reset_n |->
      {config_done_light_green, cam_light_red, cam_light_green} == 5'd0)
    else $error("light lit in reset");
  c_fast: cover property (cam_acq_active[0] && $rose(cam_light_green[0]));
  c_fault: cover property (link_train_failed && $rose(cam_light_red[1]));
  c_lost: cover property ($rose(cam_light_red[0]));
endmodule
bind clsi_status_lights clsi_status_lights_properties
#(
  .LVAL_TIMEOUT_CYCLES(LVAL_TIMEOUT_CYCLES),
  .SLOW_HALF_CYCLES   (SLOW_HALF_CYCLES),
  .FAST_HALF_CYCLES   (FAST_HALF_CYCLES)
)
u_props
(
  .mclk(mclk), .reset_n(reset_n), .cam_pclk(cam_pclk), .cam_lval(cam_lval),
  .cam_acq_active(cam_acq_active), .config_loaded(config_loaded),
  .link_train_failed(link_train_failed), .link_enumerated(link_enumerated),
  .dual_connector_mode(dual_connector_mode),
  .config_done_light_green(config_done_light_green),
  .cam_light_red(cam_light_red), .cam_light_green(cam_light_green)
);
`default_nettype wire

// ===== test/clsi_status_lights_tb.sv
// Self-checking bench for the status light driver.
`timescale 1ns/100ps
`default_nettype none
module clsi_status_lights_tb;
  localparam int SLOW = 40;
  localparam int FAST = 8;
  localparam int WIN  = 160;
  logic       mclk    = 1'b0;
  logic       reset_n = 1'b1;
  logic [1:0] run = '0, lval_on = '0, acq = '0;
  wire logic [1:0] pclk, lval, red, grn;
  logic       cfg = 1'b0, fail = 1'b0, enum_ok = 1'b0, dual = 1'b0;
  wire logic  cfg_g;
  int         n_mismatch = 0, checks_done = 0, gt, rt;
  always #5 mclk = ~mclk;
  clsi_camera_model cam0
  (
    .run    (run[0]),
    .lval_on(lval_on[0]),
    .pclk   (pclk[0]),
    .lval   (lval[0])
  );
  clsi_camera_model cam1
  (
    .run    (run[1]),
    .lval_on(lval_on[1]),
    .pclk   (pclk[1]),
    .lval   (lval[1])
  );
  clsi_status_lights
  #(
    .LVAL_TIMEOUT_CYCLES(200),
    .SLOW_HALF_CYCLES   (SLOW),
    .FAST_HALF_CYCLES   (FAST)
  )
  dut
  (
    .mclk(mclk), .reset_n(reset_n), .cam_pclk(pclk), .cam_lval(lval),
    .cam_acq_active(acq), .config_loaded(cfg), .link_train_failed(fail),
    .link_enumerated(enum_ok), .dual_connector_mode(dual),
    .config_done_light_green(cfg_g), .cam_light_red(red),
    .cam_light_green(grn)
  );
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Counts colour changes of one light over a fixed window.
  task automatic watch(input int i);
    logic g, r;
    {g, r, gt, rt} = {grn[i], red[i], 64'd0};
    repeat (WIN)
    begin
      @(negedge mclk);
      gt += int'(grn[i] !== g);
      rt += int'(red[i] !== r);
      {g, r} = {grn[i], red[i]};
    end
  endtask
  task automatic wait_green(input int i);
    int k;
    for (k = 0; k < 60 && grn[i] !== 1'b1; k++)
      tick(1);
    if (k == 60)
    begin
      chk("clock detect", 8'h00, 8'h01);
      finish_test();
    end
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    // Assert off time zero so that every asynchronous reset sees an edge.
    #1 reset_n = 1'b0;
    tick(3);
    chk("dark in reset", {3'd0, cfg_g, red, grn}, 8'h00);
    reset_n = 1'b1;
    tick(6);
    chk("config off", 8'(cfg_g), 8'h00);
    chk("no clock", {4'd0, red, grn}, 8'h0c);
    cfg = 1'b1;
    tick(6);
    chk("config on", 8'(cfg_g), 8'h01);
  endtask
  task automatic t_flash();
    run = 2'b11;
    wait_green(0);
    wait_green(1);
    chk("clock only", {4'd0, red, grn}, 8'h03);
    lval_on = 2'b11;
    tick(60);
    for (int i = 0; i < 2; i++)
    begin
      watch(i);
      chk("slow toggles", 8'(gt), 8'(WIN / SLOW));
      chk("slow red", 8'(rt), 8'h00);
    end
    acq = 2'b11;
    tick(2);
    for (int i = 0; i < 2; i++)
    begin
      watch(i);
      chk("fast toggles", 8'(gt), 8'(WIN / FAST));
    end
    acq = 2'b00;
    lval_on = 2'b00;
  endtask
  task automatic t_fault();
    fail = 1'b1;
    tick(2);
    watch(1);
    chk("fault red", 8'(rt), 8'(WIN / SLOW));
    chk("fault green", 8'(gt), 8'h00);
    enum_ok = 1'b1;
    tick(2);
    watch(1);
    chk("enumerated", {7'd0, red[1]} | 8'(rt), 8'h00);
    {fail, enum_ok} = 2'b00;
  endtask
  task automatic t_miswire();
    dual = 1'b1;
    tick(20);
    chk("dual ok", 8'(red[1]), 8'h00);
    run[0] = 1'b0;
    tick(980);
    chk("clock held", 8'(red[0]), 8'h00);
    tick(120);
    chk("clock lost", 8'(red[0]), 8'h01);
    watch(1);
    chk("miswired", 8'(rt), 8'(WIN / SLOW));
    run[0] = 1'b1;
    wait_green(0);
    tick(4);
    chk("miswire gone", 8'(red[1]), 8'h00);
    dual = 1'b0;
  endtask
  initial
  begin
    t_reset();
    t_flash();
    t_fault();
    t_miswire();
    reset_n = 1'b0;
    tick(1);
    chk("dark on reset", {3'd0, cfg_g, red, grn}, 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire
